// [hw/belm_pkg.sv]
package belm_pkg;
  localparam int LOG_DEPTH = 1024;
  localparam int ALMOST_MARGIN = 16;
  localparam logic [7:0] EXT_ID = 8'h02;
  localparam logic [7:0] POL_NOCHANGE = 8'h00;
  localparam logic [7:0] POL_STOP = 8'h01;
  localparam logic [7:0] POL_CIRC = 8'h02;
  localparam logic [7:0] CC_OK = 8'h00;
  localparam logic [7:0] CC_INVALID_FIELD = 8'hCC;
  localparam logic [7:0] CC_CANNOT_EXEC = 8'hD6;
  localparam logic [7:0] SENS_LOG_STATUS = 8'h10;
  localparam logic [7:0] OFS_LOG_CLEARED = 8'h02;
  localparam logic [7:0] OFS_LOG_FULL = 8'h04;
  localparam logic [7:0] OFS_LOG_ALMOST = 8'h05;
  localparam logic [7:0] SENS_SYS_EVENT = 8'h12;
  localparam logic [7:0] OFS_TS_SYNC = 8'h05;
  localparam logic [7:0] RECEIVER_RESET = 8'h20;
  localparam int TICK_NS = 1000000000;
  localparam int CLK_NS = 25;
  localparam int TICK_CYCLES = TICK_NS / CLK_NS;

  typedef struct packed {
    logic [7:0] sensor_type;
    logic [7:0] offset;
    logic [31:0] data;
  } belm_event_t;

  typedef struct packed {
    logic [31:0] stamp;
    belm_event_t ev;
  } belm_record_t;

  typedef struct packed {
    logic [7:0] ext_id;
    logic [7:0] control;
  } belm_pol_req_t;

  typedef struct packed {
    logic [7:0] ccode;
    logic [7:0] ext_id;
    logic [7:0] policy;
  } belm_pol_rsp_t;
endpackage

// [hw/belm_top.sv]
`timescale 1ns/10ps
module belm_top #(
  parameter int DEPTH = belm_pkg::LOG_DEPTH,
  parameter bit CIRC_SUPPORT = 1'b1,
  parameter bit HAS_RTC = 1'b0,
  parameter int TICK_CYC = belm_pkg::TICK_CYCLES
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic ev_valid_i,
  input wire belm_pkg::belm_event_t ev_i,
  output logic ev_ready_o,
  input wire logic clear_i,
  input wire logic pol_valid_i,
  input wire belm_pkg::belm_pol_req_t pol_req_i,
  output belm_pkg::belm_pol_rsp_t pol_rsp_o,
  output logic pol_rsp_valid_o,
  output logic time_req_o,
  input wire logic time_valid_i,
  input wire logic [31:0] time_i,
  input wire logic time_lost_i,
  input wire logic rcv_wr_i,
  input wire logic [7:0] rcv_addr_i,
  output logic [7:0] rcv_addr_o,
  output logic fwd_valid_o,
  output belm_pkg::belm_record_t fwd_o,
  input wire logic fwd_ready_i,
  input wire logic rd_valid_i,
  input wire logic [$clog2(DEPTH)-1:0] rd_id_i,
  output belm_pkg::belm_record_t rd_data_o,
  output logic [$clog2(DEPTH):0] count_o,
  output logic full_o,
  output logic almost_full_o,
  output logic policy_circ_o
);
  localparam int AW = $clog2(DEPTH);

  // A smaller log breaks the capacity rule, and the wrap of head_ff needs a power of two.
  if (DEPTH < belm_pkg::LOG_DEPTH || (1 << AW) != DEPTH || TICK_CYC < 1)
  begin : g_param_check
    $error("belm_top: unsupported parameters");
  end

  typedef enum logic [1:0] {ST_IDLE, ST_PRE, ST_POST} belm_sync_t;

  belm_pkg::belm_record_t mem [DEPTH];

  logic [31:0] stamp_ff, nxt_stamp;
  logic [31:0] tick_ff, nxt_tick;
  logic [31:0] new_time_ff, nxt_new_time;
  belm_sync_t sync_ff, nxt_sync;
  logic need_time_ff, nxt_need_time;
  logic [AW-1:0] head_ff, nxt_head;
  logic [AW:0] count_ff, nxt_count;
  logic circ_ff, nxt_circ;
  logic full_ff, nxt_full;
  logic almost_ff, nxt_almost;
  logic [7:0] rcv_ff, nxt_rcv;
  logic fwd_valid_ff, nxt_fwd_valid;
  belm_pkg::belm_record_t fwd_ff, nxt_fwd;
  belm_pkg::belm_pol_rsp_t rsp_ff, nxt_rsp;
  logic rsp_valid_ff, nxt_rsp_valid;
  belm_pkg::belm_record_t rd_ff;

  logic int_valid;
  belm_pkg::belm_event_t int_ev;
  logic gen;
  belm_pkg::belm_event_t gen_ev;
  logic store;
  logic [AW-1:0] wr_addr;

  // Status events outrank sync events, which outrank external ones.
  logic pend_full_ff, nxt_pend_full;
  logic pend_almost_ff, nxt_pend_almost;
  logic pend_clear_ff, nxt_pend_clear;

  always_comb
  begin
    int_valid = 1'b0;
    int_ev = '0;
    int_ev.sensor_type = belm_pkg::SENS_LOG_STATUS;
    if (clear_i || pend_clear_ff)
    begin
      int_valid = 1'b1;
      int_ev.offset = belm_pkg::OFS_LOG_CLEARED;
    end
    else if (full_ff && !fwd_valid_ff && count_ff == DEPTH[AW:0] && pend_full_ff)
    begin
      int_valid = 1'b1;
      int_ev.offset = belm_pkg::OFS_LOG_FULL;
    end
    else if (pend_almost_ff)
    begin
      int_valid = 1'b1;
      int_ev.offset = belm_pkg::OFS_LOG_ALMOST;
    end
    else if (sync_ff != ST_IDLE)
    begin
      int_valid = 1'b1;
      int_ev.sensor_type = belm_pkg::SENS_SYS_EVENT;
      int_ev.offset = belm_pkg::OFS_TS_SYNC;
      int_ev.data = {31'h0, sync_ff == ST_POST};
    end
  end

  // Only one event is generated per cycle; an external one waits its turn.
  assign gen = (int_valid || ev_valid_i) && !fwd_valid_ff;
  assign gen_ev = int_valid ? int_ev : ev_i;
  assign ev_ready_o = !int_valid && !fwd_valid_ff;
  assign store = gen && !clear_i && (count_ff != DEPTH[AW:0] || circ_ff);
  assign wr_addr = AW'(head_ff + count_ff[AW-1:0]);

  always_comb
  begin
    nxt_tick = tick_ff + 32'h1;
    nxt_stamp = stamp_ff;
    if (tick_ff >= 32'(TICK_CYC - 1))
    begin
      nxt_tick = '0;
      nxt_stamp = stamp_ff + 32'h1;
    end
    nxt_sync = sync_ff;
    nxt_new_time = new_time_ff;
    nxt_need_time = need_time_ff | time_lost_i;
    if (time_valid_i && need_time_ff && sync_ff == ST_IDLE)
    begin
      nxt_new_time = time_i;
      nxt_sync = ST_PRE;
      nxt_need_time = time_lost_i;
    end
    else if (sync_ff == ST_PRE && gen && int_ev.sensor_type == belm_pkg::SENS_SYS_EVENT)
    begin
      nxt_stamp = new_time_ff;
      nxt_tick = '0;
      nxt_sync = ST_POST;
    end
    else if (sync_ff == ST_POST && gen && int_ev.sensor_type == belm_pkg::SENS_SYS_EVENT)
      nxt_sync = ST_IDLE;
  end

  always_comb
  begin
    nxt_head = head_ff;
    nxt_count = count_ff;
    if (clear_i)
    begin
      nxt_head = '0;
      nxt_count = '0;
    end
    else if (store)
    begin
      if (count_ff == DEPTH[AW:0])
        nxt_head = AW'(head_ff + 1'b1);
      else
        nxt_count = count_ff + 1'b1;
    end
    nxt_full = (nxt_count == DEPTH[AW:0]);
    nxt_almost = (nxt_count >= (AW + 1)'(DEPTH - belm_pkg::ALMOST_MARGIN));
    nxt_pend_full = (pend_full_ff | (nxt_full & ~full_ff)) & ~clear_i;
    if (gen && int_valid && int_ev.offset == belm_pkg::OFS_LOG_FULL &&
        int_ev.sensor_type == belm_pkg::SENS_LOG_STATUS)
      nxt_pend_full = nxt_full & ~full_ff;
    nxt_pend_almost = (pend_almost_ff | (nxt_almost & ~almost_ff)) & ~clear_i;
    if (gen && int_valid && int_ev.offset == belm_pkg::OFS_LOG_ALMOST &&
        int_ev.sensor_type == belm_pkg::SENS_LOG_STATUS)
      nxt_pend_almost = nxt_almost & ~almost_ff;
    // A clear that meets a busy forward slot is held, so its status event is not lost.
    nxt_pend_clear = (clear_i | pend_clear_ff) & fwd_valid_ff;
  end

  always_comb
  begin
    nxt_fwd_valid = fwd_valid_ff;
    nxt_fwd = fwd_ff;
    if (fwd_valid_ff && fwd_ready_i)
      nxt_fwd_valid = 1'b0;
    if (gen)
    begin
      nxt_fwd_valid = 1'b1;
      nxt_fwd.stamp = stamp_ff;
      nxt_fwd.ev = gen_ev;
    end
    nxt_rcv = rcv_wr_i ? rcv_addr_i : rcv_ff;
  end

  always_comb
  begin
    nxt_circ = circ_ff;
    nxt_rsp = rsp_ff;
    nxt_rsp_valid = pol_valid_i;
    if (pol_valid_i)
    begin
      nxt_rsp.ccode = belm_pkg::CC_OK;
      if (pol_req_i.ext_id != belm_pkg::EXT_ID)
        nxt_rsp.ccode = belm_pkg::CC_INVALID_FIELD;
      else if (pol_req_i.control == belm_pkg::POL_STOP)
        nxt_circ = 1'b0;
      else if (pol_req_i.control == belm_pkg::POL_CIRC)
      begin
        if (CIRC_SUPPORT)
          nxt_circ = 1'b1;
        else
          nxt_rsp.ccode = belm_pkg::CC_CANNOT_EXEC;
      end
      else if (pol_req_i.control != belm_pkg::POL_NOCHANGE)
        nxt_rsp.ccode = belm_pkg::CC_INVALID_FIELD;
      nxt_rsp.ext_id = belm_pkg::EXT_ID;
      nxt_rsp.policy = nxt_circ ? belm_pkg::POL_CIRC : belm_pkg::POL_STOP;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      stamp_ff <= '0;
      tick_ff <= '0;
      new_time_ff <= '0;
      sync_ff <= ST_IDLE;
      need_time_ff <= 1'b1;
      head_ff <= '0;
      count_ff <= '0;
      circ_ff <= 1'b0;
      full_ff <= 1'b0;
      almost_ff <= 1'b0;
      pend_full_ff <= 1'b0;
      pend_almost_ff <= 1'b0;
      pend_clear_ff <= 1'b0;
      rcv_ff <= belm_pkg::RECEIVER_RESET;
      fwd_valid_ff <= 1'b0;
      fwd_ff <= '0;
      rsp_ff <= '0;
      rsp_valid_ff <= 1'b0;
    end
    else
    begin
      stamp_ff <= nxt_stamp;
      tick_ff <= nxt_tick;
      new_time_ff <= nxt_new_time;
      sync_ff <= nxt_sync;
      need_time_ff <= nxt_need_time & ~HAS_RTC;
      head_ff <= nxt_head;
      count_ff <= nxt_count;
      circ_ff <= nxt_circ;
      full_ff <= nxt_full;
      almost_ff <= nxt_almost;
      pend_full_ff <= nxt_pend_full;
      pend_almost_ff <= nxt_pend_almost;
      pend_clear_ff <= nxt_pend_clear;
      rcv_ff <= nxt_rcv;
      fwd_valid_ff <= nxt_fwd_valid;
      fwd_ff <= nxt_fwd;
      rsp_ff <= nxt_rsp;
      rsp_valid_ff <= nxt_rsp_valid;
    end
  end

  // The record array has no reset so it can map onto block memory.
  always_ff @(posedge clk_i)
  begin
    if (store)
    begin
      mem[wr_addr].stamp <= stamp_ff;
      mem[wr_addr].ev <= gen_ev;
    end
    if (rd_valid_i)
      rd_ff <= mem[AW'(head_ff + rd_id_i)];
  end

  assign time_req_o = need_time_ff & ~HAS_RTC;
  assign rcv_addr_o = rcv_ff;
  assign fwd_valid_o = fwd_valid_ff;
  assign fwd_o = fwd_ff;
  assign rd_data_o = rd_ff;
  assign pol_rsp_o = rsp_ff;
  assign pol_rsp_valid_o = rsp_valid_ff;
  assign count_o = count_ff;
  assign full_o = full_ff;
  assign almost_full_o = almost_ff;
  assign policy_circ_o = circ_ff;
endmodule // belm_top

// [verif/belm_monitor.sv]
`timescale 1ns/10ps
module belm_monitor #(
  parameter int DEPTH = 32
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic clear_i,
  input wire logic pol_valid_i,
  input wire belm_pkg::belm_pol_req_t pol_req_i,
  input wire belm_pkg::belm_pol_rsp_t pol_rsp_o,
  input wire logic pol_rsp_valid_o,
  input wire logic time_req_o,
  input wire logic time_lost_i,
  input wire logic fwd_valid_o,
  input wire belm_pkg::belm_record_t fwd_o,
  input wire logic fwd_ready_i,
  input wire logic [$clog2(DEPTH):0] count_o,
  input wire logic full_o,
  input wire logic policy_circ_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  rsp_latency_a: assert property (pol_valid_i |=> pol_rsp_valid_o)
    else $error("policy answer missing");
  rsp_ext_a: assert property (pol_rsp_valid_o |-> pol_rsp_o.ext_id == 8'h02)
    else $error("answer ext id wrong");
  reserved_keep_a: assert property (pol_valid_i && pol_req_i.control > 8'h02 |=>
    pol_rsp_o.ccode == 8'hCC && policy_circ_o == $past(policy_circ_o))
    else $error("reserved control mishandled");
  circ_select_a: assert property (pol_valid_i && pol_req_i == 16'h0202 |=>
    policy_circ_o && pol_rsp_o == 24'h000202)
    else $error("circular select failed");
  fwd_hold_a: assert property (fwd_valid_o && !fwd_ready_i |=> fwd_valid_o && $stable(fwd_o))
    else $error("forwarded event dropped");
  full_count_a: assert property (full_o |-> count_o == DEPTH)
    else $error("full flag without full count");
  clear_empty_a: assert property (clear_i |=> !full_o && count_o <= 1)
    else $error("clear left records");
  relearn_time_a: assert property (time_lost_i |-> ##[1:2] time_req_o)
    else $error("lost time not requested");
endmodule // belm_monitor

// [verif/belm_cm_model.sv]
`timescale 1ns/10ps
module belm_cm_model #(
  parameter logic [31:0] NOW = 32'h1234_5678
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic time_req_i,
  input wire logic stall_i,
  output logic time_valid_o,
  output logic [31:0] time_o,
  output logic fwd_ready_o
);
  logic [1:0] wait_ff;
  // A stall holds the event slot full, so the device must keep its offer up.
  assign fwd_ready_o = !stall_i;
  // The reply lags the request like a remote answer; time_o is scrambled outside it.
  always @(negedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      wait_ff <= 2'h0;
      time_valid_o <= 1'b0;
      time_o <= ~NOW;
    end
    else
    begin
      time_valid_o <= time_req_i && wait_ff == 2'h3;
      time_o <= (time_req_i && wait_ff == 2'h3) ? NOW : ~NOW;
      wait_ff <= time_req_i ? wait_ff + 2'h1 : 2'h0;
    end
  end
endmodule // belm_cm_model

// [verif/testbench.sv]
`timescale 1ns/10ps
module testbench;
  localparam int DEPTH = belm_pkg::LOG_DEPTH;
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_COUNT = (AW + 1)'(DEPTH);
  localparam logic [31:0] NOW = 32'h1234_5678;
  logic clk_i, nrst_i, ev_valid_i, ev_ready_o, clear_i, pol_valid_i, pol_rsp_valid_o, stall;
  logic time_req_o, time_valid_i, time_lost_i, rcv_wr_i, fwd_valid_o, fwd_ready_i, rd_valid_i;
  logic full_o, almost_full_o, policy_circ_o;
  logic [31:0] time_i;
  logic [7:0] rcv_addr_i, rcv_addr_o;
  logic [AW-1:0] rd_id_i;
  logic [AW:0] count_o;
  belm_pkg::belm_event_t ev_i;
  belm_pkg::belm_pol_req_t pol_req_i;
  belm_pkg::belm_pol_rsp_t pol_rsp_o;
  belm_pkg::belm_record_t fwd_o, rd_data_o, seen[$];
  int errors, n_tests, cyc;
  logic [39:0] tab [8] = '{40'h0201000201, 40'h0200000201, 40'h0202000202, 40'h0200000202,
    40'h0203CC0202, 40'h02FFCC0202, 40'h0301CC0202, 40'h0201000201};
  belm_top #(.DEPTH(DEPTH), .TICK_CYC(4)) uut (.clk_i, .nrst_i, .ev_valid_i, .ev_i, .ev_ready_o,
    .clear_i, .pol_valid_i, .pol_req_i, .pol_rsp_o, .pol_rsp_valid_o, .time_req_o, .time_valid_i,
    .time_i, .time_lost_i, .rcv_wr_i, .rcv_addr_i, .rcv_addr_o, .fwd_valid_o, .fwd_o, .fwd_ready_i,
    .rd_valid_i, .rd_id_i, .rd_data_o, .count_o, .full_o, .almost_full_o, .policy_circ_o);
  belm_cm_model #(.NOW(NOW)) cm (.clk_i, .nrst_i, .time_req_i(time_req_o), .stall_i(stall),
    .time_valid_o(time_valid_i), .time_o(time_i), .fwd_ready_o(fwd_ready_i));
  initial
  begin
    clk_i = 0;
    forever #12.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i)
  begin
    cyc++;
    if (fwd_valid_o && fwd_ready_i) seen.push_back(fwd_o);
    if (cyc == 20000)
    begin
      errors++;
      final_report();
    end
  end
  task automatic check(string what, logic [79:0] got, logic [79:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  function automatic int found(logic [15:0] key);
    int n;
    n = 0;
    foreach (seen[i]) if ({seen[i].ev.sensor_type, seen[i].ev.offset} == key) n++;
    return n;
  endfunction
  task automatic send_ev(logic [31:0] d);
    @(negedge clk_i);
    ev_valid_i = 1;
    ev_i = {8'hC1, 8'h07, d};
    #1 while (!ev_ready_o) @(negedge clk_i) #1;
    @(negedge clk_i);
    ev_valid_i = 0;
  endtask
  task automatic t_pol(logic [15:0] req, logic [23:0] exp);
    @(negedge clk_i);
    pol_valid_i = 1;
    pol_req_i = req;
    @(negedge clk_i);
    pol_valid_i = 0;
    check("policy answer", {pol_rsp_valid_o, pol_rsp_o}, {1'b1, exp});
  endtask
  task automatic read_rec(logic [AW-1:0] id, output belm_pkg::belm_record_t r);
    @(negedge clk_i);
    rd_valid_i = 1;
    rd_id_i = id;
    @(negedge clk_i);
    rd_valid_i = 0;
    r = rd_data_o;
  endtask
  task automatic t_sync(int n0);
    int a, b, k;
    a = 0;
    b = 0;
    for (k = 0; time_req_o && k < 100; k++) @(negedge clk_i);
    repeat (20) @(negedge clk_i);
    foreach (seen[i]) if ({seen[i].ev.sensor_type, seen[i].ev.offset} == 16'h1205) {a, b} = {b, i};
    check("sync count", found(16'h1205), n0 + 2);
    check("pre sync", seen[a].ev.data[0], 0);
    check("post sync", seen[b].ev.data[0], 1);
    check("post stamp", seen[b].stamp - NOW < 4, 1);
  endtask
  task automatic t_fill(bit circ);
    belm_pkg::belm_record_t r0, r1, r;
    int n2, n4, n5;
    n2 = found(16'h1002);
    n4 = found(16'h1004);
    n5 = found(16'h1005);
    t_pol({8'h02, 7'h00, circ} + 16'h1, {16'h0002, 7'h00, circ} + 24'h1);
    stall = 1;
    @(negedge clk_i);
    clear_i = 1;
    @(negedge clk_i);
    clear_i = 0;
    repeat (3) @(negedge clk_i);
    stall = 0;
    check("full after clear", {full_o, almost_full_o}, 0);
    for (int i = 0; i < DEPTH + 2; i++) send_ev(i);
    repeat (10) @(negedge clk_i);
    check("cleared event", found(16'h1002) > n2, 1);
    check("full event", found(16'h1004) > n4, 1);
    check("almost event", found(16'h1005) > n5, 1);
    check("full count", {full_o, almost_full_o, count_o}, {2'h3, FULL_COUNT});
    read_rec(0, r0);
    read_rec(1, r1);
    send_ev(32'hABCD_0000);
    repeat (5) @(negedge clk_i);
    check("sent when full", seen[$].ev.data, 32'hABCD_0000);
    read_rec(0, r);
    check("oldest record", r, circ ? r1 : r0);
    read_rec(AW'(DEPTH - 1), r);
    if (circ) check("newest record", r.ev.data, 32'hABCD_0000);
  endtask
  initial
  begin
    {nrst_i, ev_valid_i, clear_i, pol_valid_i, time_lost_i, rcv_wr_i, rd_valid_i, stall} = '0;
    {ev_i, pol_req_i, rcv_addr_i, rd_id_i, errors, n_tests, cyc} = '0;
    repeat (2) @(negedge clk_i);
    check("receiver at reset", rcv_addr_o, 8'h20);
    check("time request", time_req_o, 1);
    nrst_i = 1;
    t_sync(0);
    foreach (tab[i]) t_pol(tab[i][39:24], tab[i][23:0]);
    t_fill(0);
    t_fill(1);
    @(negedge clk_i);
    rcv_wr_i = 1;
    rcv_addr_i = 8'h5A;
    @(negedge clk_i);
    rcv_wr_i = 0;
    check("receiver set", rcv_addr_o, 8'h5A);
    time_lost_i = 1;
    @(negedge clk_i);
    time_lost_i = 0;
    @(negedge clk_i);
    check("time re-request", time_req_o, 1);
    t_sync(found(16'h1205));
    nrst_i = 0;
    @(negedge clk_i);
    check("time after reset", time_req_o, 1);
    check("receiver after reset", rcv_addr_o, 8'h20);
    nrst_i = 1;
    t_sync(found(16'h1205));
    final_report();
  end
endmodule // testbench
bind belm_top belm_monitor #(.DEPTH(DEPTH)) mon (.clk_i, .nrst_i, .clear_i, .pol_valid_i,
  .pol_req_i, .pol_rsp_o, .pol_rsp_valid_o, .time_req_o, .time_lost_i, .fwd_valid_o, .fwd_o,
  .fwd_ready_i, .count_o, .full_o, .policy_circ_o);
